// [verilog/fifo_modes_pkg.sv]
// Shared constants and types for the word FIFO device and its host controller
package fifo_modes_pkg;
  // ==========================================================================
  // Queue geometry and tags
  localparam int WORD_W = 16;
  localparam int DEPTH = 8;
  localparam logic [3:0] TAG_COLLIDE = 4'hE;
  localparam logic [3:0] TAG_EMPTY = 4'hF;
  // Flag word and configuration bit positions
  localparam int BIT_OVF = 8;
  localparam int BIT_EMPTY = 9;
  localparam int BIT_MON = 10;
  localparam int BIT_STAT = 11;
  localparam int GAIN_LSB = 4;
  localparam int CAL_TRACK_BIT = 0;
  localparam int CAL_DO_BIT = 1;
  localparam logic [15:0] HWCFG_RST = 16'h0000;
  // ==========================================================================
  // Timing at the 10 MHz clock; least times round up
  localparam int CLK_MHZ = 10;
  localparam int STREAM_GAP_NS = 60000;
  localparam int MSG_GAP_NS = 50000;
  localparam int CAL_WAIT_NS = 2000;
  localparam int TRACK_GAP_NS = 13000000;
  localparam int STREAM_GAP_CYC = (STREAM_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int MSG_GAP_CYC = (MSG_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int CAL_WAIT_CYC = (CAL_WAIT_NS * CLK_MHZ + 999) / 1000;
  localparam int TRACK_GAP_CYC = TRACK_GAP_NS / 1000 * CLK_MHZ;
  // ==========================================================================
  // Host register map (byte addresses) and responses
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RESP = 8'h08;
  localparam logic [7:0] REG_CFG = 8'h0C;
  localparam int CMD_OP_LSB = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================================
  // Link commands and device modes
  typedef enum logic [2:0] {
    OP_FIFO_WR = 3'b000,
    OP_FIFO_RD = 3'b001,
    OP_FLAG_RD = 3'b010,
    OP_HWCFG_WR = 3'b011,
    OP_SHDN_WR = 3'b100,
    OP_STREAM = 3'b101,
    OP_MESSAGE = 3'b110,
    OP_CAL = 3'b111
  } op_t;
  typedef enum logic [1:0] {
    MODE_NORM = 2'b00,
    MODE_STREAM = 2'b01,
    MODE_MSG = 2'b10
  } mode_t;
endpackage : fifo_modes_pkg

// [verilog/word_link_if.sv]
// Command and answer link between the host controller and the FIFO device
`timescale 1ns/1ps
interface word_link_if;
  logic cmd_valid;
  fifo_modes_pkg::op_t cmd_op;
  logic [15:0] cmd_data;
  logic rsp_valid;
  logic [15:0] rsp_data;
  logic busy;
  logic alarm_n;
  modport device_end(input cmd_valid, input cmd_op, input cmd_data,
                     output rsp_valid, output rsp_data, output busy, output alarm_n);
  modport host_end(output cmd_valid, output cmd_op, output cmd_data,
                   input rsp_valid, input rsp_data, input busy, input alarm_n);
endinterface : word_link_if

// [verilog/fifo_mode_device.sv]
// Bidirectional word FIFO with monitor, streaming, message and calibration modes
`timescale 1ns/1ps
module fifo_mode_device #(
  parameter int DEPTH = fifo_modes_pkg::DEPTH,
  parameter int TRACK_GAP = fifo_modes_pkg::TRACK_GAP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  word_link_if.device_end link,
  input wire logic conv_valid,
  input wire logic [3:0] conv_chan,
  input wire logic [11:0] conv_data,
  output logic ee_req,
  output logic ee_we,
  output logic [7:0] ee_addr,
  output logic [15:0] ee_wdata,
  input wire logic ee_ack,
  input wire logic [15:0] ee_rdata,
  output logic [15:0] gate_sample,
  output logic [1:0] gain_select,
  output logic cal_active,
  output logic cal_tracking,
  input wire logic cal_done
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] CNT_KEEP = CNT_W'(DEPTH - 1);
  localparam logic [31:0] TRACK_LAST = 32'(TRACK_GAP - 1);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [DEPTH-1:0][15:0] mem;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [CNT_W-1:0] cnt;
    logic ovf;
    logic [15:0] hwcfg;
    logic wdog_en;
    fifo_modes_pkg::mode_t mode;
    logic [7:0] addr;
    logic [7:0] left;
    logic [7:0] out_left;
    logic ee_req;
    logic ee_we;
    logic [7:0] ee_addr;
    logic [15:0] ee_wdata;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic busy;
    logic alarm_n;
    logic [15:0] sample;
    logic cal_on;
    logic cal_track;
    logic cal_run;
    logic [31:0] cal_timer;
  } dev_state_t;

  dev_state_t s_ff;
  dev_state_t nxt_s;
  logic mon_push;

  // Converter results enter the queue only in the idle mode with monitoring on
  assign mon_push = conv_valid && s_ff.hwcfg[fifo_modes_pkg::BIT_MON]
                    && (s_ff.mode == fifo_modes_pkg::MODE_NORM);

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic push;
    logic pop;
    logic clear;
    logic [15:0] push_word;
    logic [11:0] flags;
    nxt_s = s_ff;
    push = 1'b0;
    pop = 1'b0;
    clear = 1'b0;
    push_word = 16'h0000;
    flags = 12'h000;
    flags[fifo_modes_pkg::BIT_OVF] = s_ff.ovf;
    flags[fifo_modes_pkg::BIT_EMPTY] = (s_ff.cnt == '0);
    nxt_s.rsp_valid = 1'b0;
    // Internal sample path never sees the read hazard
    if (conv_valid) begin
      nxt_s.sample = {conv_chan, conv_data};
    end
    // Host commands
    if (link.cmd_valid) begin
      case (link.cmd_op)
        fifo_modes_pkg::OP_FIFO_RD: begin
          nxt_s.rsp_valid = 1'b1;
          if (s_ff.cnt == '0 || s_ff.mode == fifo_modes_pkg::MODE_STREAM) begin
            nxt_s.rsp_data = {fifo_modes_pkg::TAG_EMPTY, flags};
          end else begin
            pop = 1'b1;
            nxt_s.rsp_data = s_ff.mem[s_ff.rp];
            if (mon_push && s_ff.cnt >= CNT_KEEP) begin
              nxt_s.rsp_data[15:12] = fifo_modes_pkg::TAG_COLLIDE;
            end
            if (s_ff.mode == fifo_modes_pkg::MODE_MSG && s_ff.out_left != 8'h00) begin
              nxt_s.out_left = s_ff.out_left - 8'h01;
            end
          end
        end
        fifo_modes_pkg::OP_FIFO_WR: begin
          if (s_ff.mode == fifo_modes_pkg::MODE_STREAM) begin
            if (s_ff.cnt == CNT_FULL) begin
              nxt_s.ovf = 1'b1;
            end else begin
              push = 1'b1;
              push_word = link.cmd_data;
            end
          end
        end
        fifo_modes_pkg::OP_FLAG_RD: begin
          nxt_s.rsp_valid = 1'b1;
          nxt_s.rsp_data = {4'h0, flags};
          nxt_s.ovf = 1'b0;
        end
        fifo_modes_pkg::OP_HWCFG_WR: begin
          nxt_s.hwcfg = link.cmd_data;
        end
        fifo_modes_pkg::OP_SHDN_WR: begin
          nxt_s.wdog_en = link.cmd_data[0];
        end
        fifo_modes_pkg::OP_STREAM: begin
          if (!s_ff.wdog_en && s_ff.mode == fifo_modes_pkg::MODE_NORM) begin
            nxt_s.mode = fifo_modes_pkg::MODE_STREAM;
            clear = 1'b1;
            nxt_s.addr = link.cmd_data[7:0];
            nxt_s.left = link.cmd_data[15:8];
          end
        end
        fifo_modes_pkg::OP_MESSAGE: begin
          if (s_ff.mode == fifo_modes_pkg::MODE_NORM) begin
            nxt_s.mode = fifo_modes_pkg::MODE_MSG;
            clear = 1'b1;
            nxt_s.addr = link.cmd_data[7:0];
            nxt_s.left = link.cmd_data[15:8];
            nxt_s.out_left = link.cmd_data[15:8];
          end
        end
        fifo_modes_pkg::OP_CAL: begin
          nxt_s.cal_on = link.cmd_data[fifo_modes_pkg::CAL_DO_BIT];
          nxt_s.cal_track = link.cmd_data[fifo_modes_pkg::CAL_TRACK_BIT];
          nxt_s.cal_run = link.cmd_data[fifo_modes_pkg::CAL_DO_BIT];
          nxt_s.cal_timer = 32'h0000_0000;
        end
        default: begin
        end
      endcase
    end
    // Monitor results; past seven stored, the oldest is dropped
    if (mon_push) begin
      push = 1'b1;
      push_word = {conv_chan, conv_data};
      if (s_ff.cnt >= CNT_KEEP) begin
        nxt_s.ovf = 1'b1;
        if (!pop) begin
          pop = 1'b1;
        end
      end
    end
    // EEPROM engine: finish an access, else start the next one
    if (s_ff.ee_req) begin
      if (ee_ack) begin
        nxt_s.ee_req = 1'b0;
        if (!s_ff.ee_we && s_ff.mode == fifo_modes_pkg::MODE_MSG) begin
          push = 1'b1;
          push_word = ee_rdata;
        end
      end
    end else if (s_ff.mode == fifo_modes_pkg::MODE_STREAM && s_ff.left != 8'h00
                 && s_ff.cnt != '0 && !clear) begin
      nxt_s.ee_req = 1'b1;
      nxt_s.ee_we = 1'b1;
      nxt_s.ee_addr = s_ff.addr;
      nxt_s.ee_wdata = s_ff.mem[s_ff.rp];
      pop = 1'b1;
      nxt_s.addr = s_ff.addr + 8'h01;
      nxt_s.left = s_ff.left - 8'h01;
    end else if (s_ff.mode == fifo_modes_pkg::MODE_MSG && s_ff.left != 8'h00
                 && s_ff.cnt != CNT_FULL && !clear) begin
      nxt_s.ee_req = 1'b1;
      nxt_s.ee_we = 1'b0;
      nxt_s.ee_addr = s_ff.addr;
      nxt_s.addr = s_ff.addr + 8'h01;
      nxt_s.left = s_ff.left - 8'h01;
    end
    // Pointer and count update
    if (push) begin
      nxt_s.mem[s_ff.wp] = push_word;
    end
    if (clear) begin
      nxt_s.wp = '0;
      nxt_s.rp = '0;
      nxt_s.cnt = '0;
    end else begin
      nxt_s.wp = s_ff.wp + PTR_W'(push);
      nxt_s.rp = s_ff.rp + PTR_W'(pop);
      nxt_s.cnt = s_ff.cnt + CNT_W'(push) - CNT_W'(pop);
    end
    // Message mode flag tracks fullness
    if (nxt_s.mode == fifo_modes_pkg::MODE_MSG) begin
      nxt_s.ovf = (nxt_s.cnt == CNT_FULL);
    end
    // Mode exit once every word is moved
    if (nxt_s.mode == fifo_modes_pkg::MODE_STREAM && nxt_s.left == 8'h00 && !nxt_s.ee_req) begin
      nxt_s.mode = fifo_modes_pkg::MODE_NORM;
    end
    if (nxt_s.mode == fifo_modes_pkg::MODE_MSG && nxt_s.left == 8'h00 && !nxt_s.ee_req
        && nxt_s.out_left == 8'h00) begin
      nxt_s.mode = fifo_modes_pkg::MODE_NORM;
    end
    // Calibration: acquisition once until done, tracking repeats after a gap
    if (s_ff.cal_run && cal_done && !(link.cmd_valid && link.cmd_op == fifo_modes_pkg::OP_CAL)) begin
      nxt_s.cal_run = 1'b0;
      nxt_s.cal_timer = 32'h0000_0000;
    end else if (!s_ff.cal_run && s_ff.cal_on && s_ff.cal_track) begin
      if (s_ff.cal_timer == TRACK_LAST) begin
        nxt_s.cal_run = 1'b1;
        nxt_s.cal_timer = 32'h0000_0000;
      end else begin
        nxt_s.cal_timer = s_ff.cal_timer + 32'h0000_0001;
      end
    end
    // Registered outputs
    nxt_s.busy = (nxt_s.mode != fifo_modes_pkg::MODE_NORM) || nxt_s.cal_run;
    nxt_s.alarm_n = !(nxt_s.hwcfg[fifo_modes_pkg::BIT_STAT]
      && ((nxt_s.mode == fifo_modes_pkg::MODE_STREAM && nxt_s.cnt == CNT_FULL)
       || (nxt_s.mode == fifo_modes_pkg::MODE_MSG && nxt_s.cnt == '0)));
  end

  // ==========================================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
      s_ff.hwcfg <= fifo_modes_pkg::HWCFG_RST;
      s_ff.wdog_en <= 1'b1;
      s_ff.alarm_n <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign link.rsp_valid = s_ff.rsp_valid;
  assign link.rsp_data = s_ff.rsp_data;
  assign link.busy = s_ff.busy;
  assign link.alarm_n = s_ff.alarm_n;
  assign ee_req = s_ff.ee_req;
  assign ee_we = s_ff.ee_we;
  assign ee_addr = s_ff.ee_addr;
  assign ee_wdata = s_ff.ee_wdata;
  assign gate_sample = s_ff.sample;
  assign gain_select = s_ff.hwcfg[fifo_modes_pkg::GAIN_LSB +: 2];
  assign cal_active = s_ff.cal_run;
  assign cal_tracking = s_ff.cal_track;
endmodule : fifo_mode_device

// [verilog/fifo_mode_host.sv]
// Host controller: AXI4-Lite registers driving the FIFO device link
`timescale 1ns/1ps
module fifo_mode_host (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  word_link_if.host_end link,
  input wire logic dac_powered
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic pace_en;
    logic pend;
    fifo_modes_pkg::op_t pend_op;
    logic [15:0] pend_data;
    logic wd_off;
    logic wdog_due;
    logic in_stream;
    logic in_msg;
    logic busy_q;
    logic [15:0] resp;
    logic resp_new;
    logic [9:0] gap;
    logic [7:0] cal_cnt;
    logic cmd_valid;
    fifo_modes_pkg::op_t cmd_op;
    logic [15:0] cmd_data;
  } host_state_t;

  localparam logic [7:0] CAL_WAIT = 8'(fifo_modes_pkg::CAL_WAIT_CYC);
  localparam logic [9:0] STREAM_GAP = 10'(fifo_modes_pkg::STREAM_GAP_CYC - 1);
  localparam logic [9:0] MSG_GAP = 10'(fifo_modes_pkg::MSG_GAP_CYC - 1);

  host_state_t s_ff;
  host_state_t nxt_s;

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic paced;
    logic blocked;
    nxt_s = s_ff;
    nxt_s.cmd_valid = 1'b0;
    // Write channel: address and data in either order
    if (awvalid && s_ff.awready) begin
      nxt_s.aw_got = 1'b1;
      nxt_s.awaddr = awaddr;
    end
    if (wvalid && s_ff.wready) begin
      nxt_s.w_got = 1'b1;
      nxt_s.wdata = wdata;
      nxt_s.wstrb = wstrb;
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
      nxt_s.aw_got = 1'b0;
      nxt_s.w_got = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = fifo_modes_pkg::RESP_OKAY;
      if (s_ff.awaddr == fifo_modes_pkg::REG_CMD) begin
        if (!s_ff.pend && s_ff.wstrb[2:0] == 3'h7) begin
          nxt_s.pend = 1'b1;
          nxt_s.pend_op = fifo_modes_pkg::op_t'(s_ff.wdata[fifo_modes_pkg::CMD_OP_LSB +: 3]);
          nxt_s.pend_data = s_ff.wdata[15:0];
        end
      end else if (s_ff.awaddr == fifo_modes_pkg::REG_CFG) begin
        if (s_ff.wstrb[0]) begin
          nxt_s.pace_en = s_ff.wdata[0];
        end
      end else if (s_ff.awaddr != fifo_modes_pkg::REG_STATUS
                   && s_ff.awaddr != fifo_modes_pkg::REG_RESP) begin
        nxt_s.bresp = fifo_modes_pkg::RESP_SLVERR;
      end
    end
    // Read channel
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = fifo_modes_pkg::RESP_OKAY;
      case (araddr)
        fifo_modes_pkg::REG_CMD: nxt_s.rdata = {13'h0000, s_ff.pend_op, s_ff.pend_data};
        fifo_modes_pkg::REG_STATUS: nxt_s.rdata = {25'h000_0000, s_ff.pend, s_ff.resp_new,
          s_ff.in_msg, s_ff.in_stream, link.alarm_n, link.busy, s_ff.pace_en};
        fifo_modes_pkg::REG_RESP: begin
          nxt_s.rdata = {16'h0000, s_ff.resp};
          nxt_s.resp_new = 1'b0;
        end
        fifo_modes_pkg::REG_CFG: nxt_s.rdata = {31'h0000_0000, s_ff.pace_en};
        default: begin
          nxt_s.rdata = 32'h0000_0000;
          nxt_s.rresp = fifo_modes_pkg::RESP_SLVERR;
        end
      endcase
    end
    // Device answers; a new answer wins over a clearing read
    if (link.rsp_valid) begin
      nxt_s.resp = link.rsp_data;
      nxt_s.resp_new = 1'b1;
    end
    // Mode tracking from the busy line
    nxt_s.busy_q = link.busy;
    if (s_ff.busy_q && !link.busy) begin
      nxt_s.in_msg = 1'b0;
      if (s_ff.in_stream) begin
        nxt_s.in_stream = 1'b0;
        nxt_s.wdog_due = 1'b1;
      end
    end
    if (s_ff.gap != 10'h000) begin
      nxt_s.gap = s_ff.gap - 10'h001;
    end
    // Settling count after converter power-up
    if (!dac_powered) begin
      nxt_s.cal_cnt = 8'h00;
    end else if (s_ff.cal_cnt != CAL_WAIT) begin
      nxt_s.cal_cnt = s_ff.cal_cnt + 8'h01;
    end
    // Command launch
    paced = s_ff.pace_en
      && ((s_ff.pend_op == fifo_modes_pkg::OP_FIFO_WR && s_ff.in_stream)
       || (s_ff.pend_op == fifo_modes_pkg::OP_FIFO_RD && s_ff.in_msg));
    blocked = (paced && s_ff.gap != 10'h000)
      || (s_ff.pend_op == fifo_modes_pkg::OP_CAL
          && (link.busy || s_ff.cal_cnt != CAL_WAIT));
    if (!s_ff.cmd_valid) begin
      if (s_ff.wdog_due) begin
        nxt_s.wdog_due = 1'b0;
        nxt_s.cmd_valid = 1'b1;
        nxt_s.cmd_op = fifo_modes_pkg::OP_SHDN_WR;
        nxt_s.cmd_data = 16'h0001;
      end else if (s_ff.pend && !blocked) begin
        nxt_s.cmd_valid = 1'b1;
        nxt_s.cmd_op = s_ff.pend_op;
        nxt_s.cmd_data = s_ff.pend_data;
        if (s_ff.pend_op == fifo_modes_pkg::OP_STREAM && !s_ff.wd_off) begin
          nxt_s.cmd_op = fifo_modes_pkg::OP_SHDN_WR;
          nxt_s.cmd_data = 16'h0000;
          nxt_s.wd_off = 1'b1;
        end else begin
          nxt_s.pend = 1'b0;
          nxt_s.wd_off = 1'b0;
          if (s_ff.pend_op == fifo_modes_pkg::OP_STREAM) begin
            nxt_s.in_stream = 1'b1;
          end
          if (s_ff.pend_op == fifo_modes_pkg::OP_MESSAGE) begin
            nxt_s.in_msg = 1'b1;
          end
          if (paced) begin
            nxt_s.gap = s_ff.in_stream ? STREAM_GAP : MSG_GAP;
          end
        end
      end
    end
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready = !nxt_s.w_got && !nxt_s.bvalid;
    nxt_s.arready = !nxt_s.rvalid;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register
  assign awready = s_ff.awready;
  assign wready = s_ff.wready;
  assign bvalid = s_ff.bvalid;
  assign bresp = s_ff.bresp;
  assign arready = s_ff.arready;
  assign rvalid = s_ff.rvalid;
  assign rdata = s_ff.rdata;
  assign rresp = s_ff.rresp;
  assign link.cmd_valid = s_ff.cmd_valid;
  assign link.cmd_op = s_ff.cmd_op;
  assign link.cmd_data = s_ff.cmd_data;
endmodule : fifo_mode_host

// [dv/link_monitor.sv]
// Concurrent checks on the word link between host controller and device
`timescale 1ns/1ps
module link_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cmd_valid,
  input wire fifo_modes_pkg::op_t cmd_op,
  input wire logic [15:0] cmd_data,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic busy,
  input wire logic alarm_n
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Read commands that must be answered
  logic rd_cmd;
  assign rd_cmd = cmd_valid && (cmd_op inside {fifo_modes_pkg::OP_FIFO_RD,
                                                fifo_modes_pkg::OP_FLAG_RD});
  // ==========================================================================
  // Answers, flag word layout and mode entry
  AST_RSP_NEXT: assert property (rd_cmd |=> rsp_valid)
    else $error("read command not answered");
  AST_RSP_CAUSE: assert property (rsp_valid |-> $past(rd_cmd))
    else $error("answer without read command");
  AST_FLAG_WORD: assert property (cmd_valid && cmd_op == fifo_modes_pkg::OP_FLAG_RD
    |=> (rsp_data & 16'hFCFF) == 16'h0000) else $error("flag word has stray bits");
  AST_EMPTY_TAG: assert property (rsp_valid && rsp_data[15:12] == 4'hF
    |-> rsp_data[9] && rsp_data[11:10] == 2'h0) else $error("empty word without empty flag");
  AST_MSG_BUSY: assert property (cmd_valid && cmd_op == fifo_modes_pkg::OP_MESSAGE
    && !busy |-> ##[1:2] busy) else $error("busy not raised in message mode");
  AST_STREAM_BUSY: assert property (cmd_valid && cmd_op == fifo_modes_pkg::OP_STREAM
    && !busy |-> ##[1:2] busy) else $error("busy not raised in streaming");
  AST_RSP_HOLD: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("answer word changed without answer");
  AST_RESET_IDLE: assert property ($rose(aresetn) |-> !busy && alarm_n && !rsp_valid)
    else $error("link not idle after reset");
endmodule : link_monitor

// [dv/tb.sv]
// Self-checking bench for the host controller and word FIFO device pair
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic awvalid = 0, wvalid = 0, arvalid = 0, conv_valid = 0, ee_ack = 0;
  logic dac_powered = 0, cal_done = 0;
  logic cal_active, cal_tracking;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [3:0] conv_chan = 0;
  logic [11:0] conv_data = 0;
  logic [15:0] ee_rdata = 0;
  logic awready, wready, bvalid, arready, rvalid, ee_req, ee_we;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, seed = 32'hD0DF;
  logic [7:0] ee_addr;
  logic [15:0] ee_wdata, gate_sample;
  logic [23:0] wq[$];
  int num_checks = 0, miscompares = 0, cyc = 0;
  word_link_if link_bus();
  // ==========================================================================
  // Both ends and the link checker
  fifo_mode_host u_fifo_mode_host (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb(4'hF), .bvalid, .bready(1'b1), .bresp, .arvalid, .arready,
    .araddr, .rvalid, .rready(1'b1), .rdata, .rresp, .link(link_bus), .dac_powered);
  fifo_mode_device #(.TRACK_GAP(16)) u_fifo_mode_device (.aclk, .aresetn, .link(link_bus),
    .conv_valid, .conv_chan, .conv_data, .ee_req, .ee_we, .ee_addr, .ee_wdata, .ee_ack,
    .ee_rdata, .gate_sample, .gain_select(), .cal_active, .cal_tracking, .cal_done);
  link_monitor u_link_monitor (.aclk(aclk), .aresetn(aresetn),
    .cmd_valid(link_bus.cmd_valid), .cmd_op(link_bus.cmd_op), .cmd_data(link_bus.cmd_data),
    .rsp_valid(link_bus.rsp_valid), .rsp_data(link_bus.rsp_data), .busy(link_bus.busy),
    .alarm_n(link_bus.alarm_n));
  // ==========================================================================
  // Clock, random source and hang guard
  always #50 aclk = ~aclk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  // Memory with random stalls; word read back is built from its address
  always @(posedge aclk) begin
    ee_ack <= ee_req && !ee_ack && rnd() % 2 == 1;
    ee_rdata <= ee_req ? {~ee_addr, ee_addr} : 16'(rnd() >> 8);
    if (ee_ack && ee_we) wq.push_back({ee_addr, ee_wdata});
  end
  // ==========================================================================
  // Register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd
  task automatic waitst(input int b, input logic v);
    logic [31:0] d;
    logic [1:0] r;
    do rd(fifo_modes_pkg::REG_STATUS, d, r); while (d[b] !== v);
  endtask : waitst
  task automatic cmd(input fifo_modes_pkg::op_t op, input logic [15:0] v);
    wr(fifo_modes_pkg::REG_CMD, {13'h0, op, v});
    waitst(6, 1'b0);
  endtask : cmd
  task automatic get(input fifo_modes_pkg::op_t op, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0] r;
    cmd(op, 16'h0000);
    waitst(5, 1'b1);
    rd(fifo_modes_pkg::REG_RESP, d, r);
    `CHK(d[15:0], e)
  endtask : get
  task automatic conv(input logic [3:0] c, input logic [11:0] d);
    conv_valid <= 1'b1;
    conv_chan <= c;
    conv_data <= d;
    @(posedge aclk);
    conv_valid <= 1'b0;
    repeat (2) @(posedge aclk);
    `CHK(gate_sample, {c, d})
  endtask : conv
  // ==========================================================================
  // Main sequence: reset, monitor, message and streaming
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] q[$];
    logic [15:0] v;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(fifo_modes_pkg::REG_STATUS, d, r);
    `CHK(d, 32'h0000_0004)
    rd(8'h10, d, r);
    `CHK({d, r}, {32'h0, fifo_modes_pkg::RESP_SLVERR})
    get(fifo_modes_pkg::OP_FIFO_RD, 16'hF200);
    cmd(fifo_modes_pkg::OP_HWCFG_WR, 16'h0400);
    for (int i = 0; i < 9; i++) begin
      v = 16'(rnd());
      v[15:12] = 4'(i % 7);
      conv(v[15:12], v[11:0]);
      q.push_back(v);
      if (q.size() > 7) void'(q.pop_front());
    end
    while (q.size() > 0) get(fifo_modes_pkg::OP_FIFO_RD, q.pop_front());
    get(fifo_modes_pkg::OP_FIFO_RD, 16'hF300);
    get(fifo_modes_pkg::OP_FLAG_RD, 16'h0300);
    get(fifo_modes_pkg::OP_FLAG_RD, 16'h0200);
    cmd(fifo_modes_pkg::OP_HWCFG_WR, 16'h0800);
    cmd(fifo_modes_pkg::OP_MESSAGE, 16'h0A20);
    repeat (200) @(posedge aclk);
    get(fifo_modes_pkg::OP_FLAG_RD, 16'h0100);
    for (int i = 0; i < 10; i++) begin
      v[7:0] = 8'h20 + 8'(i);
      v[15:8] = ~v[7:0];
      // Poll the empty flag before each read
      do begin
        cmd(fifo_modes_pkg::OP_FLAG_RD, 16'h0000);
        waitst(5, 1'b1);
        rd(fifo_modes_pkg::REG_RESP, d, r);
      end while (d[fifo_modes_pkg::BIT_EMPTY]);
      rd(fifo_modes_pkg::REG_STATUS, d, r);
      `CHK(d[1], 1'b1)
      `CHK(d[2], 1'b1)
      get(fifo_modes_pkg::OP_FIFO_RD, v);
    end
    waitst(1, 1'b0);
    wr(fifo_modes_pkg::REG_CFG, 32'h0000_0001);
    cmd(fifo_modes_pkg::OP_STREAM, 16'h0340);
    // Paced writes: a later word is held back for the stream gap
    for (int i = 0; i < 3; i++) begin
      v = 16'(rnd());
      q.push_back(v);
      wr(fifo_modes_pkg::REG_CMD, {13'h0, fifo_modes_pkg::OP_FIFO_WR, v});
      repeat (100) @(posedge aclk);
      rd(fifo_modes_pkg::REG_STATUS, d, r);
      `CHK(d[6], i > 0)
      waitst(6, 1'b0);
    end
    waitst(1, 1'b0);
    for (int i = 0; i < 3; i++) `CHK(wq.pop_front(), {8'h40 + 8'(i), q.pop_front()})
    // Calibration waits for converter power plus settling, then runs until done
    wr(fifo_modes_pkg::REG_CMD, {13'h0, fifo_modes_pkg::OP_CAL, 16'h0002});
    repeat (40) @(posedge aclk);
    dac_powered <= 1'b1;
    repeat (15) @(posedge aclk);
    rd(fifo_modes_pkg::REG_STATUS, d, r);
    `CHK(d[6], 1'b1)
    waitst(6, 1'b0);
    repeat (2) @(posedge aclk);
    `CHK({cal_active, cal_tracking}, 2'b10)
    cal_done <= 1'b1;
    @(posedge aclk);
    cal_done <= 1'b0;
    waitst(1, 1'b0);
    `CHK(cal_active, 1'b0)
    conclude();
  end
endmodule : tb
